// ===== inc/keypad_pkg.sv
// keypad_pkg: register map, field positions, reset values and bus states
// for the pin wake interrupt block; assumes a 32-bit Avalon-MM register bus
package keypad_pkg;

   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;
   localparam int PIN_MAX = 8;

   // byte addresses, one aligned word per register
   localparam logic [ADDR_W-1:0] OFS_STATUS_CONTROL = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_PIN_ENABLE = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_EDGE_SELECT = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_EVENT_STATUS = 5'h0C;
   localparam logic [ADDR_W-1:0] OFS_EVENT_MASK = 5'h10;
   localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL = 5'h14;

   // key_status_control fields
   localparam int DETECT_FLAG_BIT = 3;
   localparam int DETECT_ACK_BIT = 2;
   localparam int IRQ_REQUEST_ENABLE_BIT = 1;
   localparam int EDGE_LEVEL_SELECT_BIT = 0;

   // event status / mask fields
   localparam int EVT_W = 2;
   localparam int EVT_NEW_DETECT = 0;
   localparam int EVT_ACK_REFUSED = 1;

   localparam logic [REG_W-1:0] PIN_ENABLE_RESET = 8'h00;
   localparam logic [REG_W-1:0] EDGE_SELECT_RESET = 8'h00;
   localparam logic [EVT_W-1:0] EVENT_MASK_RESET = 2'h0;
   localparam logic [DATA_W-1:0] READ_ZERO = 32'h00000000;

   typedef enum {BUS_IDLE, BUS_ANSWER} bus_state_e;

endpackage

// ===== verification/key_pin_model.sv
// key_pin_model: behavioural keys or signal lines on the wake input pins
// assumes the bench asks for pin levels on sys_clk; levels move one edge later
`timescale 1ns/1ps
`default_nettype none
module key_pin_model
   import keypad_pkg::*;
#(
   parameter int PIN_COUNT = PIN_MAX
)
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [PIN_COUNT-1:0] level_want,
   output logic [PIN_COUNT-1:0] pins
);
   // released lines idle high, as pulled-up keys would
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pins <= '1;
      end else begin
         pins <= level_want;
      end
   end
endmodule // key_pin_model
`default_nettype wire

// ===== verification/keypad_pin_interrupt_test.sv
// keypad_pin_interrupt_test: register-level tests of the pin wake interrupt block
// assumes the Avalon-MM slave answers after one wait cycle, as handed over
`timescale 1ns/1ps
`default_nettype none
module keypad_pin_interrupt_test;
   import keypad_pkg::*;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic [ADDR_W-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [DATA_W-1:0] avs_writedata = '0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [DATA_W-1:0] avs_readdata;
   logic avs_waitrequest;
   logic [PIN_MAX-1:0] level_want = 8'hFF;
   logic [PIN_MAX-1:0] wake_input_pin;
   logic pin_wake_interrupt;
   logic irq;
   int miscompares = 0;
   int checks_done = 0;
   int cycles = 0;

   keypad_pin_interrupt keypad_pin_interrupt_inst (
      .sys_clk(sys_clk), .reset(reset), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .wake_input_pin(wake_input_pin),
      .pin_wake_interrupt(pin_wake_interrupt), .irq(irq));

   key_pin_model key_pin_model_inst (
      .sys_clk(sys_clk), .reset(reset), .level_want(level_want), .pins(wake_input_pin));

   initial begin
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         miscompares = miscompares + 1;
         print_verdict();
      end
   end

   // wake in the edge's own time step: reads see values sampled at that edge,
   // and non-blocking drives land after the design has sampled
   task automatic tick(input int n = 1);
      repeat (n) begin
         @(posedge sys_clk);
      end
   endtask

   task automatic check_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                      output logic [DATA_W-1:0] rd);
      int n;
      n = 0;
      avs_address <= a;
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= {24'h000000, d};
      do begin
         tick();
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (n >= 20) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, avs_waitrequest, 1'b0);
      end
      // value sampled at the completing edge, where waitrequest was seen low
      rd = avs_readdata;
      tick();
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      tick();
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      logic [DATA_W-1:0] dummy;
      bus(1'b1, a, d, dummy);
   endtask

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
      logic [DATA_W-1:0] got;
      bus(1'b0, a, 8'h00, got);
      check_word(got, {24'h000000, exp});
   endtask

   // model moves one edge later, detection one more
   task automatic set_pins(input logic [7:0] v);
      level_want <= v;
      tick(3);
   endtask

   initial begin
      repeat (8) @(posedge sys_clk);
      reset <= 1'b0;
      tick();
      rd_chk(OFS_STATUS_CONTROL, 8'h00);
      rd_chk(OFS_PIN_ENABLE, PIN_ENABLE_RESET);
      rd_chk(OFS_EDGE_SELECT, EDGE_SELECT_RESET);
      rd_chk(OFS_EVENT_MASK, 8'h00);
      rd_chk(OFS_EVENT_STATUS, 8'h00);
      rd_chk(OFS_PIN_LEVEL, 8'hFF);
      check_bit(irq, 1'b0);
      check_bit(pin_wake_interrupt, 1'b0);
      $display("test reset_values done");

      wr(OFS_PIN_ENABLE, 8'hA5);
      rd_chk(OFS_PIN_ENABLE, 8'hA5);
      wr(OFS_EDGE_SELECT, 8'h5A);
      rd_chk(OFS_EDGE_SELECT, 8'h5A);
      avs_byteenable <= 4'h0;
      wr(OFS_PIN_ENABLE, 8'hFF);
      avs_byteenable <= 4'hF;
      rd_chk(OFS_PIN_ENABLE, 8'hA5);
      wr(5'h18, 8'hFF);
      rd_chk(5'h18, 8'h00);
      wr(OFS_PIN_ENABLE, 8'h00);
      wr(OFS_EDGE_SELECT, 8'h00);
      // all-ones write: upper bits, flag and ack must all read zero
      wr(OFS_STATUS_CONTROL, 8'hFF);
      rd_chk(OFS_STATUS_CONTROL, 8'h03);
      wr(OFS_STATUS_CONTROL, 8'h00);
      $display("test register_access done");

      wr(OFS_PIN_ENABLE, 8'h01);
      set_pins(8'hFD);
      rd_chk(OFS_STATUS_CONTROL, 8'h00);
      set_pins(8'hFC);
      rd_chk(OFS_STATUS_CONTROL, 8'h08);
      check_bit(pin_wake_interrupt, 1'b0);
      wr(OFS_STATUS_CONTROL, 8'h02);
      tick(2);
      check_bit(pin_wake_interrupt, 1'b1);
      wr(OFS_STATUS_CONTROL, 8'h06);
      rd_chk(OFS_STATUS_CONTROL, 8'h02);
      check_bit(pin_wake_interrupt, 1'b0);
      $display("test falling_edge done");

      set_pins(8'hFF);
      rd_chk(OFS_STATUS_CONTROL, 8'h02);
      wr(OFS_EDGE_SELECT, 8'h01);
      wr(OFS_STATUS_CONTROL, 8'h06);
      set_pins(8'hFE);
      rd_chk(OFS_STATUS_CONTROL, 8'h02);
      set_pins(8'hFF);
      rd_chk(OFS_STATUS_CONTROL, 8'h0A);
      wr(OFS_STATUS_CONTROL, 8'h04);
      rd_chk(OFS_STATUS_CONTROL, 8'h00);
      check_bit(pin_wake_interrupt, 1'b0);
      $display("test rising_edge done");

      wr(OFS_EVENT_STATUS, 8'h03);
      wr(OFS_STATUS_CONTROL, 8'h01);
      rd_chk(OFS_STATUS_CONTROL, 8'h09);
      wr(OFS_STATUS_CONTROL, 8'h05);
      rd_chk(OFS_STATUS_CONTROL, 8'h09);
      rd_chk(OFS_EVENT_STATUS, 8'h03);
      set_pins(8'hFE);
      wr(OFS_STATUS_CONTROL, 8'h05);
      rd_chk(OFS_STATUS_CONTROL, 8'h01);
      wr(OFS_EDGE_SELECT, 8'h00);
      rd_chk(OFS_STATUS_CONTROL, 8'h09);
      set_pins(8'hFF);
      wr(OFS_STATUS_CONTROL, 8'h04);
      rd_chk(OFS_STATUS_CONTROL, 8'h00);
      $display("test level_mode done");

      wr(OFS_EVENT_STATUS, 8'h03);
      rd_chk(OFS_EVENT_STATUS, 8'h00);
      check_bit(irq, 1'b0);
      set_pins(8'hFE);
      rd_chk(OFS_EVENT_STATUS, 8'h01);
      check_bit(irq, 1'b0);
      wr(OFS_EVENT_MASK, 8'h01);
      rd_chk(OFS_EVENT_MASK, 8'h01);
      check_bit(irq, 1'b1);
      wr(OFS_EVENT_STATUS, 8'h01);
      tick(2);
      check_bit(irq, 1'b0);
      rd_chk(OFS_EVENT_STATUS, 8'h00);
      rd_chk(OFS_PIN_LEVEL, 8'hFE);
      $display("test interrupt done");
      print_verdict();
   end
endmodule // keypad_pin_interrupt_test
`default_nettype wire

// ===== verilog/key_event_sticky.sv
// key_event_sticky: sticky event bits, cleared by writing ones
// assumes set and clear strobes are one-cycle pulses on sys_clk
`timescale 1ns/1ps
`default_nettype none
module key_event_sticky
   import keypad_pkg::*;
#(
   parameter int WIDTH = EVT_W
)
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] set,
   input wire logic clear_stb,
   input wire logic [WIDTH-1:0] clear_bits,
   output logic [WIDTH-1:0] status
);

   logic [WIDTH-1:0] status_q;

   // a set in the clearing cycle wins, so no event is lost
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         status_q <= '0;
      end else begin
         status_q <= set | (status_q & ~(clear_stb ? clear_bits : '0));
      end
   end

   assign status = status_q;

endmodule // key_event_sticky
`default_nettype wire

// ===== verilog/key_pin_detect.sv
// key_pin_detect: one input pin's edge and level qualifier
// assumes the pin is synchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module key_pin_detect
   import keypad_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic pin,
   input wire logic pin_enable_bit,
   input wire logic pin_polarity_bit,
   input wire logic level_mode,
   output logic detect
);

   logic active;
   logic active_q;

   // polarity 0: low is active; 1: high is active
   assign active = ~(pin ^ pin_polarity_bit);

   // starts as active so a pin held active through reset is no edge
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         active_q <= 1'b1;
      end else begin
         active_q <= active;
      end
   end

   assign detect = pin_enable_bit & ((active & ~active_q) | (level_mode & active));

endmodule // key_pin_detect
`default_nettype wire

// ===== verilog/keypad_pin_interrupt.sv
// keypad_pin_interrupt: pin wake interrupt block with Avalon-MM register slave
// assumes wake pins synchronous to sys_clk and a master that holds requests
// until it samples waitrequest low
`timescale 1ns/1ps
`default_nettype none
module keypad_pin_interrupt
   import keypad_pkg::*;
#(
   parameter int PIN_COUNT = PIN_MAX
)
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [PIN_COUNT-1:0] wake_input_pin,
   output logic pin_wake_interrupt,
   output logic irq
);

   if (PIN_COUNT < 1 || PIN_COUNT > REG_W) begin : g_pin_count_check
      $error("PIN_COUNT must lie between 1 and 8");
   end

   bus_state_e bus_state_q;
   logic waitrequest_q;
   logic [DATA_W-1:0] readdata_q;
   logic [DATA_W-1:0] readdata_d;

   logic irq_request_enable_q;
   logic edge_level_select_q;
   logic detect_flag_q;
   logic [PIN_COUNT-1:0] pin_enable_q;
   logic [PIN_COUNT-1:0] key_edge_select_q;
   logic [PIN_COUNT-1:0] pin_level_q;
   logic [EVT_W-1:0] event_mask_q;
   logic [EVT_W-1:0] event_status;
   logic [EVT_W-1:0] event_set;
   logic pin_wake_interrupt_q;
   logic irq_q;

   logic [PIN_COUNT-1:0] pin_detect;
   logic detect_any;
   logic request;
   logic write_stb;
   logic ack_stb;
   logic event_clear_stb;

   // ------------------------------------------------------------------
   // bus slave: one wait state on every access
   // ------------------------------------------------------------------
   assign request = avs_read | avs_write;

   // register is written only at the edge where waitrequest is seen low;
   // data lives in byte lane 0, so that lane must be enabled
   assign write_stb = (bus_state_q == BUS_ANSWER) & avs_write & avs_byteenable[0];

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         bus_state_q <= BUS_IDLE;
         waitrequest_q <= 1'b1;
      end else begin
         unique case (bus_state_q)
            BUS_IDLE: begin
               if (request) begin
                  bus_state_q <= BUS_ANSWER;
                  waitrequest_q <= 1'b0;
               end
            end
            BUS_ANSWER: begin
               bus_state_q <= BUS_IDLE;
               waitrequest_q <= 1'b1;
            end
         endcase
      end
   end

   // unmapped offsets read zero, writes to them are dropped
   always_comb begin
      readdata_d = READ_ZERO;
      unique case (avs_address)
         OFS_STATUS_CONTROL: begin
            readdata_d[DETECT_FLAG_BIT] = detect_flag_q;
            readdata_d[DETECT_ACK_BIT] = 1'b0;
            readdata_d[IRQ_REQUEST_ENABLE_BIT] = irq_request_enable_q;
            readdata_d[EDGE_LEVEL_SELECT_BIT] = edge_level_select_q;
         end
         OFS_PIN_ENABLE: readdata_d[PIN_COUNT-1:0] = pin_enable_q;
         OFS_EDGE_SELECT: readdata_d[PIN_COUNT-1:0] = key_edge_select_q;
         OFS_EVENT_STATUS: readdata_d[EVT_W-1:0] = event_status;
         OFS_EVENT_MASK: readdata_d[EVT_W-1:0] = event_mask_q;
         OFS_PIN_LEVEL: readdata_d[PIN_COUNT-1:0] = pin_level_q;
         default: readdata_d = READ_ZERO;
      endcase
   end

   // read data captured as waitrequest drops and held through the answer
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         readdata_q <= READ_ZERO;
      end else if (bus_state_q == BUS_IDLE && avs_read) begin
         readdata_q <= readdata_d;
      end
   end

   // ------------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         irq_request_enable_q <= 1'b0;
         edge_level_select_q <= 1'b0;
      end else if (write_stb && avs_address == OFS_STATUS_CONTROL) begin
         irq_request_enable_q <= avs_writedata[IRQ_REQUEST_ENABLE_BIT];
         edge_level_select_q <= avs_writedata[EDGE_LEVEL_SELECT_BIT];
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pin_enable_q <= PIN_ENABLE_RESET[PIN_COUNT-1:0];
      end else if (write_stb && avs_address == OFS_PIN_ENABLE) begin
         pin_enable_q <= avs_writedata[PIN_COUNT-1:0];
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         key_edge_select_q <= EDGE_SELECT_RESET[PIN_COUNT-1:0];
      end else if (write_stb && avs_address == OFS_EDGE_SELECT) begin
         key_edge_select_q <= avs_writedata[PIN_COUNT-1:0];
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         event_mask_q <= EVENT_MASK_RESET;
      end else if (write_stb && avs_address == OFS_EVENT_MASK) begin
         event_mask_q <= avs_writedata[EVT_W-1:0];
      end
   end

   // raw pin levels, handy for software polling
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pin_level_q <= '0;
      end else begin
         pin_level_q <= wake_input_pin;
      end
   end

   // ------------------------------------------------------------------
   // detection
   // ------------------------------------------------------------------
   for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
      key_pin_detect u_detect (
         .sys_clk(sys_clk),
         .reset(reset),
         .pin(wake_input_pin[i]),
         .pin_enable_bit(pin_enable_q[i]),
         .pin_polarity_bit(key_edge_select_q[i]),
         .level_mode(edge_level_select_q),
         .detect(pin_detect[i])
      );
   end

   assign detect_any = |pin_detect;
   assign ack_stb = write_stb && avs_address == OFS_STATUS_CONTROL
                    && avs_writedata[DETECT_ACK_BIT];

   // set wins over acknowledge; a held level re-sets the flag at once
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         detect_flag_q <= 1'b0;
      end else if (detect_any) begin
         detect_flag_q <= 1'b1;
      end else if (ack_stb) begin
         detect_flag_q <= 1'b0;
      end
   end

   // request follows the flag one cycle later
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pin_wake_interrupt_q <= 1'b0;
      end else begin
         pin_wake_interrupt_q <= detect_flag_q & irq_request_enable_q;
      end
   end

   // ------------------------------------------------------------------
   // event status, mask and interrupt line
   // ------------------------------------------------------------------
   assign event_set[EVT_NEW_DETECT] = detect_any & ~detect_flag_q;
   assign event_set[EVT_ACK_REFUSED] = ack_stb & detect_any;
   assign event_clear_stb = write_stb && avs_address == OFS_EVENT_STATUS;

   key_event_sticky #(.WIDTH(EVT_W)) u_events (
      .sys_clk(sys_clk),
      .reset(reset),
      .set(event_set),
      .clear_stb(event_clear_stb),
      .clear_bits(avs_writedata[EVT_W-1:0]),
      .status(event_status)
   );

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(event_status & event_mask_q);
      end
   end

   assign avs_readdata = readdata_q;
   assign avs_waitrequest = waitrequest_q;
   assign pin_wake_interrupt = pin_wake_interrupt_q;
   assign irq = irq_q;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   AST_BUS_ONE_WAIT: assert property (
      (bus_state_q == BUS_IDLE && request) |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("waitrequest did not drop for exactly one cycle");

   AST_UPPER_READ_ZERO: assert property (
      (bus_state_q == BUS_ANSWER && avs_read && avs_address == OFS_STATUS_CONTROL)
      |-> avs_readdata[DATA_W-1:DETECT_FLAG_BIT+1] == '0)
      else $error("unused status bits read nonzero");

   AST_ACK_READ_ZERO: assert property (
      (bus_state_q == BUS_ANSWER && avs_read && avs_address == OFS_STATUS_CONTROL)
      |-> !avs_readdata[DETECT_ACK_BIT])
      else $error("acknowledge bit read as one");

   AST_FLAG_SETS: assert property (
      detect_any |=> detect_flag_q)
      else $error("detection did not set the flag");

   AST_FLAG_WRITE_IGNORED: assert property (
      (!detect_flag_q && !detect_any && write_stb && avs_address == OFS_STATUS_CONTROL
       && avs_writedata[DETECT_FLAG_BIT]) |=> !detect_flag_q)
      else $error("software write set the flag");

   AST_ACK_CLEARS: assert property (
      (ack_stb && !detect_any) |=> !detect_flag_q)
      else $error("acknowledge did not clear the flag");

   AST_REQUEST_GATED: assert property (
      1'b1 |=> pin_wake_interrupt == $past(detect_flag_q && irq_request_enable_q))
      else $error("interrupt request does not follow flag and enable");

   AST_DISABLED_PIN_QUIET: assert property (
      (pin_detect & ~pin_enable_q) == '0)
      else $error("disabled pin produced a detection");

   AST_FALLING_EDGE: assert property (
      ($fell(wake_input_pin[0]) && pin_enable_q[0] && !key_edge_select_q[0]
       && $stable(key_edge_select_q[0])) |-> pin_detect[0] ##1 detect_flag_q)
      else $error("falling edge missed");

   AST_RISING_EDGE: assert property (
      ($rose(wake_input_pin[0]) && pin_enable_q[0] && key_edge_select_q[0]
       && $stable(key_edge_select_q[0])) |-> pin_detect[0])
      else $error("rising edge missed");

   AST_EDGE_ONLY_QUIET: assert property (
      (!edge_level_select_q && $stable(wake_input_pin[0]) && $stable(key_edge_select_q[0]))
      |-> !pin_detect[0])
      else $error("edge mode detected a steady level");

   AST_LEVEL_HOLDS_FLAG: assert property (
      (edge_level_select_q && pin_enable_q[0] && wake_input_pin[0] == key_edge_select_q[0])
      |-> pin_detect[0] ##1 detect_flag_q)
      else $error("held active level did not keep the flag set");

   AST_POLARITY_LOW: assert property (
      (edge_level_select_q && pin_enable_q[0] && !key_edge_select_q[0] && wake_input_pin[0]
       && $past(wake_input_pin[0])) |-> !pin_detect[0])
      else $error("low polarity detected a high level");

   AST_IRQ_FOLLOWS_EVENTS: assert property (
      1'b1 |=> irq == $past(|(event_status & event_mask_q)))
      else $error("irq does not follow masked events");

   AST_IDLE_WAITS: assert property (
      (bus_state_q == BUS_IDLE) |-> avs_waitrequest)
      else $error("waitrequest low outside an answer cycle");

   AST_LANE_ZERO_DROPPED: assert property (
      (bus_state_q == BUS_ANSWER && avs_write && !avs_byteenable[0]) |=> $stable(pin_enable_q)
      && $stable(key_edge_select_q) && $stable(irq_request_enable_q))
      else $error("write without byte lane 0 changed a register");

   AST_FLAG_READ_BACK: assert property (
      (bus_state_q == BUS_IDLE && avs_read && avs_address == OFS_STATUS_CONTROL)
      |=> avs_readdata[DETECT_FLAG_BIT] == $past(detect_flag_q))
      else $error("status read does not show the flag");

   AST_FLAG_STICKS: assert property (
      (detect_flag_q && !ack_stb) |=> detect_flag_q)
      else $error("flag cleared without an acknowledge");

   AST_NO_REQUEST_DISABLED: assert property (
      (!irq_request_enable_q) |=> !pin_wake_interrupt)
      else $error("interrupt requested while request enable is off");

   AST_NEW_DETECT_EVENT: assert property (
      (detect_any && !detect_flag_q) |=> event_status[EVT_NEW_DETECT])
      else $error("new detection not recorded");

   AST_ACK_REFUSED_EVENT: assert property (
      (ack_stb && detect_any) |=> event_status[EVT_ACK_REFUSED] && detect_flag_q)
      else $error("refused acknowledge not recorded");

   COV_FLAG_ACKED: cover property (detect_flag_q ##1 ack_stb ##1 !detect_flag_q);
   COV_ACK_REFUSED: cover property (ack_stb && detect_any && edge_level_select_q);
   COV_REQUEST: cover property (!pin_wake_interrupt ##1 pin_wake_interrupt);
   COV_IRQ: cover property (!irq ##1 irq);
   COV_LANE_ZERO_WRITE: cover property (bus_state_q == BUS_ANSWER && avs_write && !avs_byteenable[0]);

endmodule // keypad_pin_interrupt
`default_nettype wire
